//--- core/cnis_pkg.sv
// Package for the CAN node index selector: register map, field layouts and types
package cnis_pkg;
  // Register byte offsets
  localparam logic [7:0] CNIS_OFF_CTRL = 8'h00;
  localparam logic [7:0] CNIS_OFF_SWID = 8'h04;
  localparam logic [7:0] CNIS_OFF_ID = 8'h08;
  localparam logic [7:0] CNIS_OFF_STAT = 8'h0c;
  localparam logic [7:0] CNIS_OFF_IRQ = 8'h10;
  localparam logic [7:0] CNIS_OFF_MASK = 8'h14;
  localparam logic [7:0] CNIS_OFF_TMO = 8'h18;
  // CTRL fields: [0] software mode, [2:1] strap width code
  localparam int CNIS_CTRL_SW_BIT = 0;
  localparam int CNIS_CTRL_WID_LSB = 1;
  // Strap width codes
  localparam logic [1:0] CNIS_WID_2 = 2'h0;
  localparam logic [1:0] CNIS_WID_3 = 2'h1;
  localparam logic [1:0] CNIS_WID_4 = 2'h2;
  // Reset values
  localparam logic [6:0] CNIS_SWID_RST = 7'h01;
  localparam logic [1:0] CNIS_WID_RST = CNIS_WID_4;
  localparam logic [15:0] CNIS_TMO_RST = 16'h03e8;
  localparam logic [2:0] CNIS_IRQ_RST = 3'h0;
  // Event bits: [0] config fault, [1] primary failover, [2] link fault
  localparam int CNIS_EV_CFG = 0;
  localparam int CNIS_EV_FOVR = 1;
  localparam int CNIS_EV_LINK = 2;
  // Power-up sampling settle time and derived cycle count
  localparam int CNIS_SETTLE_NS = 100;
  localparam int CNIS_CLK_NS = 10;
  localparam logic [3:0] CNIS_SETTLE_CYC = 4'((CNIS_SETTLE_NS + CNIS_CLK_NS - 1) / CNIS_CLK_NS);

  // Loader states, Gray coded along the path
  typedef enum logic [1:0] {
    CNIS_ST_WAIT = 2'b00,
    CNIS_ST_LATCH = 2'b01,
    CNIS_ST_RUN = 2'b11
  } cnis_state_e;

  // Configuration copied at power-up
  typedef struct packed {
    logic sw_mode;
    logic [1:0] width;
    logic [6:0] sw_id;
  } cnis_cfg_s;

  // One received message word with its valid
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } cnis_msg_s;
endpackage

//--- core/cnis_top.sv
// CAN node index selector with paired-unit message source failover
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Straps sampled once at power-up only
// - Raw open/closed level, polarity ignored
// - Identity settings apply only if written in the settle window
// - Two, three or four strap widths
// - Two-input: straps 5,4 give 1..3
// - Three-input: straps 5,4,3 give 1..7
// - Four-input: straps 5,4,2,1 give 1..15
// - Software mode uses stored node identity
// - Mode resets to variant default, overridable
// - Invalid strap code keeps node off network
// - Relay direct traffic to mate over link
// - Act on network 1 while healthy
// - Switch to network 2 on fault
// - Relay over remaining link if one fails
// - Fault means no traffic within timeout
module cnis_top import cnis_pkg::*; #(
  parameter logic CNIS_SW_DEFAULT = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Raw strap inputs, bit n-1 is strap n, high means closed
  input wire logic [4:0] strap_closed,
  // Direct network message stream and mate stream
  input wire cnis_msg_s net_rx,
  input wire cnis_msg_s mate_rx0,
  input wire cnis_msg_s mate_rx1,
  // Strap for which network this unit is directly on: 0 primary
  input wire logic on_secondary,
  // Internal link health, one per link
  input wire logic [1:0] link_ok,
  // Relay to mate on both links
  output cnis_msg_s relay_tx0,
  output cnis_msg_s relay_tx1,
  // Selected message stream
  output cnis_msg_s sel_msg,
  // Node identity
  output logic [6:0] node_id,
  output logic node_en,
  // Interrupt
  output logic irq
);

  // Function decodes straps per configured width
  function automatic logic [3:0] strap_index(input logic [1:0] wid, input logic [4:0] s);
    logic [3:0] idx;
    idx = 4'h0;
    case (wid)
      CNIS_WID_2: idx = {2'b00, s[4], s[3]};
      CNIS_WID_3: idx = {1'b0, s[4], s[3], s[2]};
      CNIS_WID_4: idx = {s[4], s[3], s[1], s[0]};
      default: idx = 4'h0;
    endcase
    return idx;
  endfunction

  // Software-visible registers
  logic ctrl_sw;
  logic [1:0] ctrl_wid;
  logic [6:0] swid;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [15:0] tmo;
  // Running state
  cnis_state_e state;
  cnis_state_e next_state;
  logic [3:0] settle;
  cnis_cfg_s run_cfg;
  logic cfg_fault;
  logic use_secondary;
  logic [15:0] pri_cnt;
  logic [15:0] sec_cnt;

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire hit_ctrl = paddr == CNIS_OFF_CTRL;
  wire hit_swid = paddr == CNIS_OFF_SWID;
  wire hit_id = paddr == CNIS_OFF_ID;
  wire hit_stat = paddr == CNIS_OFF_STAT;
  wire hit_irq = paddr == CNIS_OFF_IRQ;
  wire hit_mask = paddr == CNIS_OFF_MASK;
  wire hit_tmo = paddr == CNIS_OFF_TMO;
  wire hit_any = hit_ctrl | hit_swid | hit_id | hit_stat | hit_irq | hit_mask | hit_tmo;
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_wid, ctrl_sw} :
                       hit_swid ? {25'h0, swid} :
                       hit_id ? {24'h0, node_en, node_id} :
                       hit_stat ? {28'h0, link_ok, use_secondary, cfg_fault} :
                       hit_irq ? {29'h0, irq_stat} :
                       hit_mask ? {29'h0, irq_mask} :
                       hit_tmo ? {16'h0, tmo} : 32'h0;

  // Strap decode at latch time, raw level only
  wire [3:0] strap_idx = strap_index(run_cfg.width, strap_closed);
  wire strap_bad = strap_idx == 4'h0;
  wire [6:0] next_id = run_cfg.sw_mode ? run_cfg.sw_id : {3'h0, strap_idx};
  wire next_en = run_cfg.sw_mode ? (run_cfg.sw_id != 7'h0) : ~strap_bad;

  // Streams: from network 1 and network 2, whichever path brought them
  wire [1:0] mate_ok = link_ok & {mate_rx1.valid, mate_rx0.valid};
  wire cnis_msg_s mate_msg = mate_ok[0] ? mate_rx0 : mate_rx1;
  wire cnis_msg_s mate_sel = '{valid: |mate_ok, data: mate_msg.data};
  wire cnis_msg_s pri_msg = on_secondary ? mate_sel : net_rx;
  wire cnis_msg_s sec_msg = on_secondary ? net_rx : mate_sel;
  wire pri_lost = pri_cnt >= tmo;
  wire sec_lost = sec_cnt >= tmo;
  wire ev_fovr = ~use_secondary & pri_lost & ~sec_lost & (state == CNIS_ST_RUN);
  wire ev_link = (state == CNIS_ST_RUN) & (link_ok != 2'b11);
  wire ev_cfg = (state == CNIS_ST_LATCH) & ~next_en;

  // Loader sequence: settle, latch, then run for good
  always_comb begin
    next_state = state;
    case (state)
      CNIS_ST_WAIT: if (settle == CNIS_SETTLE_CYC) next_state = CNIS_ST_LATCH;
      CNIS_ST_LATCH: next_state = CNIS_ST_RUN;
      CNIS_ST_RUN: next_state = CNIS_ST_RUN;
      default: next_state = CNIS_ST_WAIT;
    endcase
  end

  // Loader state and settle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CNIS_ST_WAIT;
      settle <= 4'h0;
    end else begin
      state <= next_state;
      if (state == CNIS_ST_WAIT) settle <= settle + 4'h1;
    end
  end

  // Configuration copied every settle cycle and frozen at latch; later writes are lost at the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cfg <= '0;
    end else if (state == CNIS_ST_WAIT) begin
      run_cfg <= '{sw_mode: ctrl_sw, width: ctrl_wid, sw_id: swid};
    end
  end

  // Identity latched once and held until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_id <= 7'h0;
      node_en <= 1'b0;
      cfg_fault <= 1'b0;
    end else if (state == CNIS_ST_LATCH) begin
      node_id <= next_en ? next_id : 7'h0;
      node_en <= next_en;
      cfg_fault <= ~next_en;
    end
  end

  // Silence counters per stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_cnt <= 16'h0;
      sec_cnt <= 16'h0;
    end else begin
      pri_cnt <= pri_msg.valid ? 16'h0 : (pri_lost ? pri_cnt : pri_cnt + 16'h1);
      sec_cnt <= sec_msg.valid ? 16'h0 : (sec_lost ? sec_cnt : sec_cnt + 16'h1);
    end
  end

  // Source select is sticky: no flapping back once failed over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_secondary <= 1'b0;
    end else if (ev_fovr) begin
      use_secondary <= 1'b1;
    end
  end

  // Relay and selected stream; held off network until identity is good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_tx0 <= '0;
      relay_tx1 <= '0;
      sel_msg <= '0;
    end else begin
      relay_tx0 <= node_en ? net_rx : '0;
      relay_tx1 <= node_en ? net_rx : '0;
      sel_msg <= node_en ? (use_secondary ? sec_msg : pri_msg) : '0;
    end
  end

  // Control registers; mode default follows the variant parameter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sw <= CNIS_SW_DEFAULT;
      ctrl_wid <= CNIS_WID_RST;
      swid <= CNIS_SWID_RST;
      irq_mask <= CNIS_IRQ_RST;
      tmo <= CNIS_TMO_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        ctrl_sw <= pwdata[CNIS_CTRL_SW_BIT];
        ctrl_wid <= pwdata[CNIS_CTRL_WID_LSB +: 2];
      end
      if (hit_swid) swid <= pwdata[6:0];
      if (hit_mask) irq_mask <= pwdata[2:0];
      if (hit_tmo) tmo <= pwdata[15:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= CNIS_IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~((apb_wr & hit_irq) ? pwdata[2:0] : 3'h0))
                  | {ev_link, ev_fovr, ev_cfg};
    end
  end

  // Interrupt output from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // APB answer: no wait state, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Loader and identity checks
  a_id_stable: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_RUN && $past(state) == CNIS_ST_RUN) |-> $stable(node_id))
    else $error("node id changed after latch");
  a_strap_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_RUN) ##1 (state == CNIS_ST_RUN) |-> $stable(node_en))
    else $error("enable changed while running");
  a_latch_once: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_LATCH) |=> (state == CNIS_ST_RUN))
    else $error("loader did not move on to run");
  a_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_RUN) |=> $stable(run_cfg))
    else $error("configuration copy moved while running");
  a_bad_off: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_fault |-> !node_en && node_id == 7'h0)
    else $error("invalid strap kept on network");
  a_en_has_id: assert property (@(posedge pclk) disable iff (!presetn)
    node_en |-> node_id != 7'h0)
    else $error("enabled without an identity");
  a_latch_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_LATCH && !run_cfg.sw_mode && strap_bad) |=> cfg_fault && !node_en)
    else $error("bad strap not faulted");
  a_hw_index: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_LATCH && !run_cfg.sw_mode && !strap_bad)
      |=> node_id == {3'h0, $past(strap_idx)})
    else $error("strap index mismatch");
  a_hw_range: assert property (@(posedge pclk) disable iff (!presetn)
    (node_en && !run_cfg.sw_mode) |-> node_id <= 7'h0f)
    else $error("strap index out of range");
  a_sw_index: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CNIS_ST_LATCH && run_cfg.sw_mode && run_cfg.sw_id != 7'h0)
      |=> node_id == $past(run_cfg.sw_id))
    else $error("software id not used");
  // Stream checks
  a_failover: assert property (@(posedge pclk) disable iff (!presetn)
    ev_fovr |=> use_secondary)
    else $error("no switch to network 2");
  a_sec_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    use_secondary |=> use_secondary)
    else $error("source fell back before reset");
  a_primary_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!use_secondary && !pri_lost) |=> !use_secondary)
    else $error("left primary while healthy");
  a_relay_path: assert property (@(posedge pclk) disable iff (!presetn)
    (node_en && net_rx.valid) |=> relay_tx0.valid && relay_tx1.valid)
    else $error("direct traffic not relayed");
  a_relay_off: assert property (@(posedge pclk) disable iff (!presetn)
    !node_en |=> (relay_tx0 == '0) && (relay_tx1 == '0))
    else $error("relay active without identity");
  a_sel_off: assert property (@(posedge pclk) disable iff (!presetn)
    !node_en |=> sel_msg == '0)
    else $error("stream passed without identity");
  a_sel_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (node_en && use_secondary && sec_msg.valid) |=> sel_msg.valid)
    else $error("secondary stream not selected");
  a_mate_backup: assert property (@(posedge pclk) disable iff (!presetn)
    (node_en && use_secondary && !on_secondary && link_ok == 2'b10 && mate_rx1.valid)
      |=> sel_msg.valid)
    else $error("remaining link not used");
  // Bus and interrupt checks
  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_fovr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ev_fovr |=> irq_stat[CNIS_EV_FOVR])
    else $error("failover not flagged");
  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && hit_irq && pwdata[CNIS_EV_FOVR] && !ev_fovr) |=> !irq_stat[CNIS_EV_FOVR])
    else $error("write one did not clear");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    |(irq_stat & irq_mask) |=> irq)
    else $error("interrupt not raised");
  a_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(irq_stat & irq_mask)) |=> !irq)
    else $error("interrupt without cause");
  // Scenario covers
  c_hw_ok: cover property (@(posedge pclk) disable iff (!presetn)
    state == CNIS_ST_LATCH && !run_cfg.sw_mode && !strap_bad);
  c_bad: cover property (@(posedge pclk) disable iff (!presetn) ev_cfg);
  c_fovr: cover property (@(posedge pclk) disable iff (!presetn) ev_fovr);
  c_one_link: cover property (@(posedge pclk) disable iff (!presetn)
    node_en && link_ok == 2'b10 && mate_rx1.valid);
  c_sec_unit: cover property (@(posedge pclk) disable iff (!presetn)
    node_en && on_secondary && use_secondary);

endmodule
`default_nettype wire

//--- testbench/cnis_far_model.sv
// Far side model: control network and mating positioner streams
`timescale 1ns/1ps
`default_nettype none
module cnis_far_model import cnis_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scenario controls
  input wire logic net_on,
  input wire logic mate_on,
  input wire logic [1:0] link_up,
  // Streams toward the unit
  output cnis_msg_s net_rx,
  output cnis_msg_s mate_rx0,
  output cnis_msg_s mate_rx1,
  output logic [1:0] link_ok
);
  logic [15:0] cnt;
  logic net_fire;
  logic m0_fire;
  logic m1_fire;
  // Network words every fourth cycle; mate words offset so the two never collide
  assign net_fire = net_on && (cnt[1:0] == 2'h0);
  assign m0_fire = mate_on && link_up[0] && (cnt[1:0] == 2'h2);
  assign m1_fire = mate_on && link_up[1] && (cnt[1:0] == 2'h2);
  assign link_ok = link_up;
  // Idle or dead lines show inverted data so stale words cannot pass as fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0;
      net_rx <= '0;
      mate_rx0 <= '0;
      mate_rx1 <= '0;
    end else begin
      cnt <= cnt + 16'h1;
      net_rx.valid <= net_fire;
      net_rx.data <= net_fire ? {16'h1000, cnt} : ~net_rx.data;
      mate_rx0.valid <= m0_fire;
      mate_rx0.data <= m0_fire ? {16'h2000, cnt} : ~mate_rx0.data;
      mate_rx1.valid <= m1_fire;
      mate_rx1.data <= m1_fire ? {16'h2000, cnt} : ~mate_rx1.data;
    end
  end
endmodule
`default_nettype wire

//--- testbench/cnis_top_tb.sv
// Self-checking bench for the CAN node index selector
`timescale 1ns/1ps
`default_nettype none
module cnis_top_tb import cnis_pkg::*;;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] strap_closed = 5'h0;
  logic on_secondary = 1'b0;
  logic net_on = 1'b1;
  logic mate_on = 1'b1;
  logic [1:0] link_up = 2'h3;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err_seen, node_en, irq;
  logic [1:0] link_ok;
  logic [6:0] node_id;
  cnis_msg_s net_rx, mate_rx0, mate_rx1, relay_tx0, relay_tx1, sel_msg;
  int errors = 0;
  int checks_done = 0;

  cnis_top u_cnis_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_closed(strap_closed), .net_rx(net_rx), .mate_rx0(mate_rx0),
    .mate_rx1(mate_rx1), .on_secondary(on_secondary), .link_ok(link_ok),
    .relay_tx0(relay_tx0), .relay_tx1(relay_tx1), .sel_msg(sel_msg), .node_id(node_id),
    .node_en(node_en), .irq(irq));
  cnis_far_model u_cnis_far_model (.pclk(pclk), .presetn(presetn), .net_on(net_on),
    .mate_on(mate_on), .link_up(link_up), .net_rx(net_rx), .mate_rx0(mate_rx0),
    .mate_rx1(mate_rx1), .link_ok(link_ok));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Index from straps: bit n-1 is strap n, closed reads as one
  function automatic logic [6:0] exp_idx(input logic [1:0] w, input logic [4:0] s);
    case (w)
      CNIS_WID_2: return {5'h0, s[4], s[3]};
      CNIS_WID_3: return {4'h0, s[4], s[3], s[2]};
      CNIS_WID_4: return {3'h0, s[4], s[3], s[1], s[0]};
      default: return 7'h0;
    endcase
  endfunction

  // Power cycle; identity settings only stick if written early in the settle window
  task automatic power_up(input logic cfg, input logic [2:0] ctrl, input logic [6:0] swid,
                          input logic [4:0] st);
    @(posedge pclk);
    presetn <= 1'b0;
    strap_closed <= st;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    if (cfg) begin
      apb(1'b1, CNIS_OFF_CTRL, {29'h0, ctrl});
      apb(1'b1, CNIS_OFF_SWID, {25'h0, swid});
      apb(1'b1, CNIS_OFF_TMO, 32'h14);
    end
    // Straps must hold past the latch, which comes 12 edges after release
    repeat (20) @(posedge pclk);
    strap_closed <= ~st;
    repeat (2) @(posedge pclk);
  endtask

  // Waits for a word on one stream and judges what the unit made of it
  task automatic watch(input int src, input int sel_mode, input int rly_mode);
    cnis_msg_s m;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      m = (src == 0) ? net_rx : (src == 1) ? mate_rx0 : mate_rx1;
      n++;
    end while (m.valid !== 1'b1 && n < 40);
    chk(66'(m.valid), 66'h1);
    @(posedge pclk);
    #1;
    if (sel_mode != 0) chk(66'(sel_msg), sel_mode == 1 ? 66'(m) : 66'h0);
    if (rly_mode != 0) chk({relay_tx0, relay_tx1}, rly_mode == 1 ? {m, m} : 66'h0);
  endtask

  task automatic t_straps();
    logic [6:0] e;
    for (int w = 0; w < 4; w++) begin
      for (int s = 0; s < 32; s++) begin
        e = exp_idx(2'(w), 5'(s));
        power_up(1'b1, {2'(w), 1'b0}, 7'h0, 5'(s));
        chk(66'({node_en, node_id}), 66'({e != 7'h0, e}));
        apb(1'b0, CNIS_OFF_STAT, 32'h0);
        chk(66'(rd[0]), 66'(e == 7'h0));
      end
    end
  endtask

  task automatic t_soft();
    power_up(1'b1, 3'h1, 7'h5a, 5'h00);
    chk(66'({node_en, node_id}), 66'({1'b1, 7'h5a}));
    apb(1'b0, CNIS_OFF_ID, 32'h0);
    chk(66'(rd), 66'({1'b1, 7'h5a}));
    apb(1'b1, CNIS_OFF_SWID, 32'h33);
    apb(1'b1, CNIS_OFF_CTRL, 32'h4);
    repeat (20) @(posedge pclk);
    chk(66'({node_en, node_id}), 66'({1'b1, 7'h5a}));
    power_up(1'b1, 3'h1, 7'h00, 5'h1f);
    chk(66'(node_en), 66'h0);
    // No early writes: the variant default of harness mode must apply
    power_up(1'b0, 3'h0, 7'h0, 5'h1f);
    chk(66'({node_en, node_id}), 66'({1'b1, exp_idx(CNIS_WID_RST, 5'h1f)}));
    apb(1'b0, CNIS_OFF_CTRL, 32'h0);
    chk(66'(rd), 66'({CNIS_WID_RST, 1'b0}));
    apb(1'b0, CNIS_OFF_SWID, 32'h0);
    chk(66'(rd), 66'(CNIS_SWID_RST));
    apb(1'b0, CNIS_OFF_TMO, 32'h0);
    chk(66'(rd), 66'(CNIS_TMO_RST));
    apb(1'b0, CNIS_OFF_MASK, 32'h0);
    chk(66'(rd), 66'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(66'({err_seen, rd}), 66'({1'b1, 32'h0}));
  endtask

  task automatic t_traffic();
    power_up(1'b1, 3'h4, 7'h0, 5'h1f);
    watch(0, 1, 1);
    apb(1'b0, CNIS_OFF_STAT, 32'h0);
    chk(66'(rd[1]), 66'h0);
    net_on <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, CNIS_OFF_STAT, 32'h0);
    chk(66'(rd[1]), 66'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, CNIS_OFF_STAT, 32'h0);
    chk(66'(rd[1]), 66'h1);
    watch(1, 1, 0);
    apb(1'b0, CNIS_OFF_IRQ, 32'h0);
    chk(66'({irq, rd[2:0]}), 66'h2);
    apb(1'b1, CNIS_OFF_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(66'(irq), 66'h1);
    apb(1'b1, CNIS_OFF_IRQ, 32'h2);
    repeat (2) @(posedge pclk);
    chk(66'(irq), 66'h0);
    // Link 0 dies: the mate stream must still arrive over link 1
    link_up <= 2'h2;
    watch(2, 1, 0);
    apb(1'b0, CNIS_OFF_STAT, 32'h0);
    chk(66'(rd[3:2]), 66'h2);
    apb(1'b0, CNIS_OFF_IRQ, 32'h0);
    chk(66'(rd[2]), 66'h1);
  endtask

  task automatic t_nocode();
    link_up <= 2'h3;
    net_on <= 1'b1;
    power_up(1'b1, 3'h0, 7'h0, 5'h00);
    watch(0, 2, 2);
    apb(1'b1, CNIS_OFF_MASK, 32'h1);
    apb(1'b0, CNIS_OFF_IRQ, 32'h0);
    chk(66'({irq, rd[0]}), 66'h3);
  endtask

  // Unit wired to network 2: the mate brings the primary stream
  task automatic t_secondary();
    on_secondary <= 1'b1;
    mate_on <= 1'b1;
    power_up(1'b1, 3'h4, 7'h0, 5'h1f);
    watch(1, 1, 0);
    watch(0, 0, 1);
    mate_on <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, CNIS_OFF_STAT, 32'h0);
    chk(66'(rd[1]), 66'h1);
    watch(0, 1, 0);
  endtask

  task automatic give_verdict();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_straps();
    t_soft();
    t_traffic();
    t_nocode();
    t_secondary();
    give_verdict();
  end

  // Watchdog, well past the roughly six thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
